// ===== src/pme_wake_pkg.sv
package pme_wake_pkg;

	// Flag byte fields.
	localparam int FLAG_ENABLE_BIT = 7;
	localparam int FLAG_PULSE_BIT = 6;
	localparam int FLAG_LONG_BIT = 5;
	localparam int FLAG_POLARITY_BIT = 4;
	localparam int FLAG_PUSHPULL_BIT = 3;
	localparam int FLAG_LINKSEL_BIT = 2;
	localparam int FLAG_TENTH_SENSE_BIT = 1;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [10:0] WAKE_ENABLES_RESET = 11'h000;
	localparam int WAKE_PIN_COUNT = 11;
	localparam int TENTH_PIN_INDEX = 10;

	// Timing.
	localparam int CLK_HZ = 25000000;
	localparam int SHORT_PULSE_US = 1500;
	localparam int LONG_PULSE_US = 150000;
	localparam int SHORT_PULSE_CYCLES = SHORT_PULSE_US * (CLK_HZ / 1000000);
	localparam int LONG_PULSE_CYCLES = LONG_PULSE_US * (CLK_HZ / 1000000);

	// Register map (byte addresses).
	localparam logic [7:0] ADDR_FLAGS = 8'h00;
	localparam logic [7:0] ADDR_WAKE_EN = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_INT_CLEAR = 8'h0C;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_STATE = 8'h14;

	// Status bits.
	localparam int ST_MAGIC = 0;
	localparam int ST_LINK = 1;
	localparam int ST_PIN = 2;
	localparam int ST_DONE = 3;
	localparam int ST_WIDTH = 4;

	typedef enum logic [2:0] {
		IDLE = 3'b001,
		ASSERT_LEVEL = 3'b010,
		ASSERT_PULSE = 3'b100
	} wake_state_t;

endpackage : pme_wake_pkg

// ===== src/pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
	parameter int WIDTH = 23
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [WIDTH-1:0] length,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic done_reg;
	logic isZero;

	assign isZero = (count_reg == '0);
	assign count_next = start ? length : (isZero ? count_reg : count_reg - 1'b1);
	assign busy = !isZero;
	assign done = done_reg;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			done_reg <= !start && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end
endmodule : pulse_timer
`default_nettype wire

// ===== src/gpio_pme_wake_signaler.sv
// Operation
// RQ1 - With the enable flag (bit 7) set, a Magic Packet, link-up or wake-pin event asserts the wake output; cleared, nothing signals.
// RQ2 - The internal-mode wake pin carries the event with the internal PHY, the external-mode wake pin with an external PHY.
// RQ3 - While the enable flag is 0 every other flag-byte parameter is ignored.
// RQ4 - Bit 6 selects level signaling (0) or pulse signaling (1).
// RQ5 - In pulse mode bit 5 gives 1.5 ms (0) or 150 ms (1).
// RQ6 - Bit 4 sets the active sense: 0 active low, 1 active high.
// RQ7 - Bit 3 selects a single-sided driver (0) or push-pull (1).
// RQ8 - A single-sided driver is open drain at polarity 0 and open source at polarity 1.
// RQ9 - Bit 2 selects Magic Packet (0) or link-up (1) as the network source beside wake pins.
// RQ10 - Link-up wakeup is never given with an external PHY.
// RQ11 - Wake-pin selection comes from the wake pin enable field loaded from bytes 1Eh and 1Fh.
// RQ12 - Bit 1 sets the detection sense of the tenth wake input pin, ignored when signaling is off.
// RQ13 - The pulse is timed by a core-clock counter and the pin then returns to inactive or high impedance.
`timescale 1ns/1ps
`default_nettype none
module gpio_pme_wake_signaler
	import pme_wake_pkg::*;
#(
	parameter int SHORT_CYCLES = SHORT_PULSE_CYCLES,
	parameter int LONG_CYCLES = LONG_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic phy_source_strap,
	input wire logic magic_packet_event,
	input wire logic link_up_event,
	input wire logic [WAKE_PIN_COUNT-1:0] wake_pins_in,
	input wire logic [WAKE_PIN_COUNT-1:0] wake_pin_polarity,
	output logic internal_mode_wake_pin_out,
	output logic internal_mode_wake_pin_oe_b,
	output logic external_mode_wake_pin_out,
	output logic external_mode_wake_pin_oe_b,
	output logic irq
);
	localparam int TW = $clog2(LONG_CYCLES + 1);

	// Refuse pulse lengths that the timer or the read path cannot hold.
	if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES || TW > 32)
	begin : gBadLengths
		$error("Pulse lengths out of range.");
	end

	logic [7:0] flags_reg;
	logic [WAKE_PIN_COUNT-1:0] wakeEn_reg;
	logic [ST_WIDTH-1:0] status_reg;
	logic [ST_WIDTH-1:0] status_next;
	logic [ST_WIDTH-1:0] intEn_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [WAKE_PIN_COUNT-1:0] pinPrev_reg;
	logic primed_reg;
	wake_state_t state_reg;
	wake_state_t state_next;

	// Bus decode.
	wire access = wb_cyc_i && wb_stb_i && !ack_reg;
	wire wrLow = access && wb_we_i && wb_sel_i[0];
	wire wrHigh = access && wb_we_i && wb_sel_i[1];
	wire hitFlags = (wb_adr_i == ADDR_FLAGS);
	wire hitWakeEn = (wb_adr_i == ADDR_WAKE_EN);
	wire hitStatus = (wb_adr_i == ADDR_STATUS);
	wire hitClear = (wb_adr_i == ADDR_INT_CLEAR);
	wire hitIntEn = (wb_adr_i == ADDR_INT_ENABLE);
	wire hitState = (wb_adr_i == ADDR_STATE);

	// Flag fields.
	wire enable = flags_reg[FLAG_ENABLE_BIT];
	wire pulseMode = flags_reg[FLAG_PULSE_BIT];
	wire longPulse = flags_reg[FLAG_LONG_BIT];
	wire polarity = flags_reg[FLAG_POLARITY_BIT];
	wire pushPull = flags_reg[FLAG_PUSHPULL_BIT];
	wire linkSel = flags_reg[FLAG_LINKSEL_BIT];
	wire tenthSense = flags_reg[FLAG_TENTH_SENSE_BIT];
	wire externalPhy = phy_source_strap;

	// Wake pin detection with per-pin sense; the tenth pin's sense comes from the flag byte.
	wire [WAKE_PIN_COUNT-1:0] pinSense;
	wire [WAKE_PIN_COUNT-1:0] pinActive;
	wire [WAKE_PIN_COUNT-1:0] pinRise;
	for (genvar i = 0; i < WAKE_PIN_COUNT; i++)
	begin : gPin
		if (i == TENTH_PIN_INDEX)
		begin : gTenth
			assign pinSense[i] = tenthSense; // [RQ12]
		end
		else
		begin : gOther
			assign pinSense[i] = wake_pin_polarity[i];
		end
		assign pinActive[i] = (wake_pins_in[i] == pinSense[i]);
		// No edge is taken in the first cycle after reset, so a pin that is already active is no fresh wake.
		assign pinRise[i] = primed_reg && pinActive[i] && !pinPrev_reg[i];
	end
	wire pinEvent = |(pinRise & wakeEn_reg); // [RQ11]

	wire magicEvent = magic_packet_event && !linkSel; // [RQ9]
	wire linkEvent = link_up_event && linkSel && !externalPhy; // [RQ9] [RQ10]
	wire wakeEvent = enable && (magicEvent || linkEvent || pinEvent); // [RQ1] [RQ3]

	// Pulse timer.
	logic timerBusy;
	logic timerDone;
	wire startPulse = (state_reg == IDLE) && wakeEvent && pulseMode; // [RQ4]
	wire [TW-1:0] pulseLen = longPulse ? TW'(LONG_CYCLES) : TW'(SHORT_CYCLES); // [RQ5]

	pulse_timer #(
		.WIDTH(TW)
	) timer (
		.clk(clk),
		.rst_b(rst_b),
		.start(startPulse),
		.length(pulseLen),
		.busy(timerBusy),
		.done(timerDone)
	);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			IDLE:
			begin
				if (wakeEvent)
					state_next = pulseMode ? ASSERT_PULSE : ASSERT_LEVEL; // [RQ4]
			end
			ASSERT_LEVEL:
			begin
				if (!enable || pulseMode)
					state_next = IDLE; // [RQ3]
			end
			ASSERT_PULSE:
			begin
				if (!enable || !timerBusy)
					state_next = IDLE; // [RQ13]
			end
			default:
				state_next = IDLE;
		endcase
	end

	// Level mode holds until software acknowledges the wake by clearing the pin, link and magic status together, or until the enable flag is cleared or bit 6 is set.
	wire levelClear = wrLow && hitClear;
	wire asserted = enable && (state_reg != IDLE); // [RQ3]

	// Pin drive.
	logic driveLevel;
	logic driveOeB;
	always_comb
	begin
		driveLevel = asserted ? polarity : !polarity; // [RQ6]
		if (!enable)
			driveOeB = 1'b1;
		else if (pushPull)
			driveOeB = 1'b0; // [RQ7]
		else
			driveOeB = !asserted; // [RQ8] [RQ13]
	end

	assign internal_mode_wake_pin_out = externalPhy ? 1'b0 : driveLevel; // [RQ2]
	assign internal_mode_wake_pin_oe_b = externalPhy ? 1'b1 : driveOeB; // [RQ2]
	assign external_mode_wake_pin_out = externalPhy ? driveLevel : 1'b0; // [RQ2]
	assign external_mode_wake_pin_oe_b = externalPhy ? driveOeB : 1'b1; // [RQ2]

	// Status: set wins over clear.
	wire [ST_WIDTH-1:0] statusSet = {timerDone, enable && pinEvent, enable && linkEvent, enable && magicEvent};
	wire [ST_WIDTH-1:0] statusClr = levelClear ? wb_dat_i[ST_WIDTH-1:0] : '0;
	assign status_next = (status_reg & ~statusClr) | statusSet;
	assign irq = |(status_reg & intEn_reg);

	// Leaving level mode also happens when one clear write sets the pin, link and magic bits together, whichever caused it.
	wire levelDone = (state_reg == ASSERT_LEVEL) && levelClear && wb_dat_i[ST_PIN] && wb_dat_i[ST_MAGIC]
		&& wb_dat_i[ST_LINK];

	logic [31:0] readMux;
	always_comb
	begin
		if (hitFlags)
			readMux = {24'h000000, flags_reg};
		else if (hitWakeEn)
			readMux = {{(32-WAKE_PIN_COUNT){1'b0}}, wakeEn_reg};
		else if (hitStatus)
			readMux = {{(32-ST_WIDTH){1'b0}}, status_reg};
		else if (hitIntEn)
			readMux = {{(32-ST_WIDTH){1'b0}}, intEn_reg};
		else if (hitState)
			readMux = {{29{1'b0}}, state_reg};
		else
			readMux = 32'h00000000;
	end

	// Bus answer: one-cycle acknowledge, read data only beside it.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			ack_reg <= access;
			rdata_reg <= (access && !wb_we_i) ? readMux : 32'h00000000;
		end
	end

	// Sticky status bits.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end

	// Wake pin history for edge detection.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinPrev_reg <= '0;
			primed_reg <= 1'b0;
		end
		else
		begin
			pinPrev_reg <= pinActive;
			primed_reg <= 1'b1;
		end
	end

	// Signaling state.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= IDLE;
		else
			state_reg <= levelDone ? IDLE : state_next;
	end

	// Flag byte.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			flags_reg <= FLAG_RESET;
		else if (wrLow && hitFlags)
			flags_reg <= wb_dat_i[7:0];
	end

	// Wake pin enables, written in two byte lanes.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wakeEn_reg <= WAKE_ENABLES_RESET;
		else
		begin
			if (wrLow && hitWakeEn)
				wakeEn_reg[7:0] <= wb_dat_i[7:0]; // [RQ11]
			if (wrHigh && hitWakeEn)
				wakeEn_reg[10:8] <= wb_dat_i[10:8]; // [RQ11]
		end
	end

	// Interrupt enables.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			intEn_reg <= '0;
		else if (wrLow && hitIntEn)
			intEn_reg <= wb_dat_i[ST_WIDTH-1:0];
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
endmodule : gpio_pme_wake_signaler
`default_nettype wire

// ===== tb/gpio_pme_wake_signaler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pme_wake_signaler_asserts
	import pme_wake_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic phy_source_strap,
	input wire logic internal_mode_wake_pin_out,
	input wire logic internal_mode_wake_pin_oe_b,
	input wire logic external_mode_wake_pin_out,
	input wire logic external_mode_wake_pin_oe_b
);
	logic [7:0] flags_reg;
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire ps = phy_source_strap;
	wire iOeB = internal_mode_wake_pin_oe_b;
	wire eOeB = external_mode_wake_pin_oe_b;
	wire selOeB = ps ? eOeB : iOeB;
	wire selOut = ps ? external_mode_wake_pin_out : internal_mode_wake_pin_out;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			flags_reg <= 8'h00;
		else if (req && wb_we_i && wb_adr_i == ADDR_FLAGS)
			flags_reg <= wb_dat_i[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
	a_ackOne: assert property (p_ackOne) else $error("ack too long");
	property p_ackReq; req |=> wb_ack_o; endproperty
	a_ackReq: assert property (p_ackReq) else $error("ack missing");
	property p_ackCause; $rose(wb_ack_o) |-> $past(req); endproperty
	a_ackCause: assert property (p_ackCause) else $error("stray ack");
	property p_datIdle; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
	a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
	property p_off; !flags_reg[7] && $stable(flags_reg) |-> iOeB && eOeB; endproperty
	a_off: assert property (p_off) else $error("pin driven while off");
	property p_unsel; $stable(ps) |-> (ps ? iOeB : eOeB); endproperty
	a_unsel: assert property (p_unsel) else $error("wrong pin driven");
	property p_push; flags_reg[7] && flags_reg[3] && $stable(flags_reg) && $stable(ps) |-> !selOeB; endproperty
	a_push: assert property (p_push) else $error("push-pull released");
	property p_single; flags_reg[7] && !flags_reg[3] && !selOeB |-> selOut == flags_reg[4]; endproperty
	a_single: assert property (p_single) else $error("single-sided level");
endmodule : gpio_pme_wake_signaler_asserts
`default_nettype wire

// ===== tb/pme_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pme_host_model (
	input wire logic pinOut,
	input wire logic pinOeB,
	input wire logic pullHigh,
	output logic wakeLevel
);
	// A released line rests at the host's pull resistor level.
	assign wakeLevel = pinOeB ? pullHigh : pinOut;
endmodule : pme_host_model
`default_nettype wire

// ===== tb/gpio_pme_wake_signaler_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pme_wake_signaler_test;
	import pme_wake_pkg::*;
	localparam int SC = 20;
	localparam int LC = 50;
	typedef struct {logic [7:0] f; logic p; int ev; int n;} row_t;
	logic clk, iw, ew, io, iob, eo, eob, irq, ack;
	logic rst_b = 1'h0, we = 1'h0, cyc = 1'h0, stb = 1'h0, ps = 1'h0, mp = 1'h0, lu = 1'h0, pu = 1'h1, ieOn = 1'h1;
	logic [7:0] adr = 8'h00;
	logic [10:0] pins = 11'h000;
	logic [31:0] dw = 32'h0, dr, dout;
	int fail_count = 0, tests_run = 0, tick = 0;
	row_t rows[9] = '{'{8'h78, 1'h0, 0, 0}, '{8'h98, 1'h0, 0, 100}, '{8'hC8, 1'h0, 0, SC}, '{8'hF0, 1'h1, 0, LC},
		'{8'hC0, 1'h1, 0, SC}, '{8'h8C, 1'h0, 1, 100}, '{8'h8C, 1'h0, 0, 0}, '{8'h8C, 1'h1, 1, 0}, '{8'h98, 1'h0, 1, 0}};
	gpio_pme_wake_signaler #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) dut (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr),
		.wb_dat_i(dw), .wb_dat_o(dout), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.phy_source_strap(ps), .magic_packet_event(mp), .link_up_event(lu), .wake_pins_in(pins),
		.wake_pin_polarity(11'h7FF), .internal_mode_wake_pin_out(io), .internal_mode_wake_pin_oe_b(iob),
		.external_mode_wake_pin_out(eo), .external_mode_wake_pin_oe_b(eob), .irq(irq));
	pme_host_model hostIn (.pinOut(io), .pinOeB(iob), .pullHigh(pu), .wakeLevel(iw));
	pme_host_model hostEx (.pinOut(eo), .pinOeB(eob), .pullHigh(pu), .wakeLevel(ew));
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		tick <= tick + 1;
		if (tick == 20000)
		begin
			fail_count++;
			close_out();
		end
	end
	task automatic close_out;
		$display("tests %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dw <= d;
		do
			@(posedge clk);
		while (ack !== 1'h1);
		dr = dout;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : bus
	task automatic run(input row_t r);
		int n;
		bus(1'h1, ADDR_FLAGS, {24'h0, r.f});
		ps <= r.p;
		pu <= ~r.f[4];
		@(posedge clk);
		case (r.ev)
			0: mp <= 1'h1;
			1: lu <= 1'h1;
			default: pins[10] <= 1'h1;
		endcase
		@(posedge clk);
		mp <= 1'h0;
		lu <= 1'h0;
		pins[10] <= 1'h0;
		n = 0;
		repeat (100)
		begin
			@(negedge clk);
			if ((ps ? ew : iw) === r.f[4])
				n++;
		end
		chk(n >= r.n && n <= r.n + 1, 1'h1);
		chk(irq, ieOn && (r.n == SC || r.n == LC));
		$display("row %h done", r.f);
	endtask : run
	initial
	begin
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		bus(1'h0, ADDR_FLAGS, 32'h0);
		chk(dr, FLAG_RESET);
		bus(1'h0, ADDR_STATE, 32'h0);
		chk(dr, 32'h1);
		bus(1'h0, 8'h40, 32'h0);
		chk(dr, 32'h0);
		bus(1'h1, ADDR_INT_ENABLE, 32'h8);
		foreach (rows[i])
		begin
			run(rows[i]);
			bus(1'h1, ADDR_INT_CLEAR, 32'hF);
			@(negedge clk);
			chk(irq, 1'h0);
		end
		bus(1'h1, ADDR_FLAGS, 32'hCA);
		bus(1'h1, ADDR_WAKE_EN, 32'h400);
		bus(1'h1, ADDR_INT_ENABLE, 32'h0);
		ieOn = 1'h0;
		run('{8'hCA, 1'h0, 2, SC});
		bus(1'h1, ADDR_INT_ENABLE, 32'h8);
		@(negedge clk);
		chk(irq, 1'h1);
		bus(1'h1, ADDR_INT_CLEAR, 32'hF);
		@(negedge clk);
		chk(irq, 1'h0);
		$display("interrupt mask done");
		close_out();
	end
endmodule : gpio_pme_wake_signaler_test
bind gpio_pme_wake_signaler gpio_pme_wake_signaler_asserts chk_i (.clk(clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .phy_source_strap(phy_source_strap),
	.internal_mode_wake_pin_out(internal_mode_wake_pin_out),
	.internal_mode_wake_pin_oe_b(internal_mode_wake_pin_oe_b),
	.external_mode_wake_pin_out(external_mode_wake_pin_out),
	.external_mode_wake_pin_oe_b(external_mode_wake_pin_oe_b));
`default_nettype wire
